// ===== rtl/tmr_defines.svh
// constants for the timer/prescaler block
// Operation
// - count source select overrides pin direction; the code overrides only while the comparator count select picks the pin
// - prescaler output sampled on Q2 and Q4; the code samples the external count source before the prescaler instead
// - increment three to seven periods after edge
// - one prescaler, timer or watchdog, never both
// - assign bit selects owner, ratio field selects ratio
// - timer count write clears prescaler; the code clears it only while the timer owns the prescaler
// - watchdog clear clears prescaler and watchdog; the code clears the prescaler only while the watchdog owns it
// - prescaler hidden from software, zero after reset
// - assignment may change any time
// - internal mode counts every instruction cycle; the code does so only while the watchdog owns the prescaler
// - count write inhibits two instruction cycles
// - edge select picks rising or falling edge
// - assign clear gives ratios 1:2 to 1:256
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
// register byte addresses on the apb bus
`define ADDR_TIMER_COUNT 12'h000
`define ADDR_OPTION 12'h004
`define ADDR_CMP_ONE 12'h008
`define ADDR_CMP_TWO 12'h00C
`define ADDR_COMMAND 12'h010
`define ADDR_STATUS 12'h014
// option_control fields
`define OPT_SRC_BIT 5
`define OPT_EDGE_BIT 4
`define OPT_ASSIGN_BIT 3
`define OPT_RATIO_HI 2
`define OPT_RATIO_LO 0
// comparator_one_control: count select bit
`define CMP_COUNT_SEL_BIT 4
// command register bits
`define CMD_WDT_CLEAR_BIT 0
// reset values
`define OPTION_RESET 8'hFF
`define CMP_RESET 8'hFF
// last phase of the instruction cycle and suppression length
`define PHASE_COUNT 2'h3
`define INHIBIT_CYCLES 2'h2
`endif

// ===== rtl/tmr_pkg.sv
// types for the timer/prescaler block
package tmr_pkg;
   // apb request bundle
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   // apb answer bundle
   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;
endpackage : tmr_pkg

// ===== rtl/edge_sync.sv
// two-phase sampler and edge detector for the external count source
`timescale 1ns/100ps
`default_nettype none
module edge_sync
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic sample_en,
   input wire logic din,
   input wire logic fall_sel,
   output logic edge_pulse
);
   logic s1_q, s1_d; // first stage, read only by second
   logic s2_q, s2_d; // second stage
   logic s3_q, s3_d; // previous sampled value
   always_comb
   begin
      s1_d = sample_en ? din : s1_q;
      s2_d = sample_en ? s1_q : s2_q;
      s3_d = sample_en ? s2_q : s3_q;
   end
   // registers of the sampler
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end
      else
      begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
      end
   end
   assign edge_pulse = sample_en & (fall_sel ? (s3_q & ~s2_q) : (~s3_q & s2_q));
endmodule : edge_sync
`default_nettype wire

// ===== rtl/timer0_prescaler_sync.sv
// timer/counter with shared prescaler, apb register slave
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "tmr_defines.svh"
module timer0_prescaler_sync
   import tmr_pkg::*;
#(
   parameter int PRESCALE_WIDTH = 8
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire tmr_pkg::apb_req_t apb_req,
   output tmr_pkg::apb_rsp_t apb_rsp,
   input wire logic ext_count_pin,
   input wire logic comparator_out,
   input wire logic watchdog_tick,
   output logic pin_direction_override,
   output logic watchdog_clear,
   output logic watchdog_timeout_tick,
   output logic [7:0] timer_count
);
   import tmr_pkg::*;

   // each system clock is one oscillator phase; four make an instruction cycle
   logic [1:0] phase_q, phase_d;
   logic [7:0] count_q, count_d; // timer_count register
   logic [7:0] option_q, option_d; // option_control register
   logic [7:0] cmp1_q, cmp1_d; // comparator_one_control
   logic [7:0] cmp2_q, cmp2_d; // comparator_two_control
   logic [PRESCALE_WIDTH-1:0] pre_q, pre_d; // hidden prescaler
   logic [1:0] inhibit_q, inhibit_d; // instruction cycles still blocked
   logic wclr_q, wclr_d; // watchdog clear pulse out
   logic wtick_q, wtick_d; // postscaled watchdog tick out
   logic pdir_q, pdir_d; // pin direction override out
   logic pre_fall; // selected prescaler tap fell on a counting step
   apb_rsp_t rsp_q, rsp_d; // registered apb answer

   logic count_source_select;
   logic count_edge_select;
   logic prescaler_assign;
   logic [2:0] prescale_ratio;
   logic comparator_count_select;
   logic ext_src; // external count source after mux
   logic ext_edge; // synchronised edge event
   logic instr_tick; // one pulse per instruction cycle
   logic sample_phase; // q2 or q4 phase
   logic wr_access; // apb write completing now
   logic rd_access; // apb read in either access cycle
   logic wr_count; // write to timer_count
   logic wdt_clear_cmd; // watchdog clear instruction
   logic timer_pre; // prescaler belongs to timer
   logic inc_src; // raw increment event before prescale
   logic inc_now; // final increment

   assign count_source_select = option_q[`OPT_SRC_BIT];
   assign count_edge_select = option_q[`OPT_EDGE_BIT];
   assign prescaler_assign = option_q[`OPT_ASSIGN_BIT];
   assign prescale_ratio = option_q[`OPT_RATIO_HI:`OPT_RATIO_LO];
   assign comparator_count_select = cmp1_q[`CMP_COUNT_SEL_BIT];
   assign timer_pre = ~prescaler_assign;

   // phases 1 and 3 stand for q2 and q4; phase 3 closes the instruction cycle
   assign instr_tick = (phase_q == `PHASE_COUNT);
   assign sample_phase = phase_q[0];

   // apb: one wait state; writes land only on the access cycle that shows pready
   assign wr_access = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_q.pready;
   assign rd_access = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   assign wr_count = wr_access & (apb_req.paddr == `ADDR_TIMER_COUNT);
   assign wdt_clear_cmd = wr_access & (apb_req.paddr == `ADDR_COMMAND)
      & apb_req.pwdata[`CMD_WDT_CLEAR_BIT];

   // pin when comparator select set, else comparator output
   assign ext_src = comparator_count_select ? ext_count_pin : comparator_out;

   // three stage sampling sets the latency window
   edge_sync u_sync
   (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .sample_en(sample_phase),
      .din(ext_src),
      .fall_sel(count_edge_select),
      .edge_pulse(ext_edge)
   );

   // internal source counts each instruction cycle
   assign inc_src = count_source_select ? ext_edge : instr_tick;

   // phase counter, free running
   always_comb
   begin
      phase_d = phase_q + 2'h1;
   end

   // prescaler: counts timer events or watchdog ticks depending on owner
   always_comb
   begin
      pre_d = pre_q;
      pre_fall = 1'b0;
      if (timer_pre && wr_count)
      begin
         pre_d = '0;
      end
      else if (!timer_pre && wdt_clear_cmd)
      begin
         pre_d = '0;
      end
      // owner may change without stopping either side
      else if (timer_pre ? inc_src : watchdog_tick)
      begin
         pre_d = pre_q + {{(PRESCALE_WIDTH-1){1'b0}}, 1'b1};
         // a clear must not look like a divided event, so only a step may fall the tap
         pre_fall = pre_q[prescale_ratio] & ~pre_d[prescale_ratio];
      end
   end

   // timer ratio 1:2 up to 1:256 via tap edge
   // suppress increments after a count write
   always_comb
   begin
      inc_now = 1'b0;
      if (timer_pre)
      begin
         // falling tap = one full divided period
         inc_now = pre_fall;
      end
      else
      begin
         inc_now = inc_src;
      end
      if (inhibit_q != 2'h0)
      begin
         inc_now = 1'b0;
      end
   end

   // timer count, inhibit counter and outputs
   always_comb
   begin
      count_d = count_q;
      inhibit_d = inhibit_q;
      wtick_d = 1'b0;
      wclr_d = 1'b0;
      // pin override when external source selected and the pin is the count source
      pdir_d = count_source_select & comparator_count_select;
      if (wr_count)
      begin
         count_d = apb_req.pwdata[7:0];
         inhibit_d = `INHIBIT_CYCLES;
      end
      else
      begin
         if (instr_tick && inhibit_q != 2'h0)
         begin
            inhibit_d = inhibit_q - 2'h1;
         end
         if (inc_now)
         begin
            count_d = count_q + 8'h01;
         end
      end
      // watchdog undivided when timer owns prescaler
      if (timer_pre)
      begin
         wtick_d = watchdog_tick;
      end
      else
      begin
         wtick_d = pre_fall;
      end
      wclr_d = wdt_clear_cmd;
   end

   // control registers and apb answer
   always_comb
   begin
      option_d = option_q;
      cmp1_d = cmp1_q;
      cmp2_d = cmp2_q;
      rsp_d = '0;
      // ready follows the first access cycle, so registered read data is in place
      rsp_d.pready = apb_req.psel & apb_req.penable & ~rsp_q.pready;
      if (wr_access)
      begin
         unique case (apb_req.paddr)
            `ADDR_OPTION: option_d = apb_req.pwdata[7:0];
            `ADDR_CMP_ONE: cmp1_d = apb_req.pwdata[7:0];
            `ADDR_CMP_TWO: cmp2_d = apb_req.pwdata[7:0];
            default: ;
         endcase
      end
      // write error decided on the first access cycle; status writes are ignored
      if (apb_req.psel && apb_req.penable && apb_req.pwrite)
      begin
         unique case (apb_req.paddr)
            `ADDR_OPTION, `ADDR_CMP_ONE, `ADDR_CMP_TWO: ;
            `ADDR_TIMER_COUNT, `ADDR_COMMAND, `ADDR_STATUS: ;
            default: rsp_d.pslverr = 1'b1;
         endcase
      end
      if (rd_access)
      begin
         unique case (apb_req.paddr)
            `ADDR_TIMER_COUNT: rsp_d.prdata = {24'h00_0000, count_q};
            `ADDR_OPTION: rsp_d.prdata = {24'h00_0000, option_q};
            `ADDR_CMP_ONE: rsp_d.prdata = {24'h00_0000, cmp1_q};
            `ADDR_CMP_TWO: rsp_d.prdata = {24'h00_0000, cmp2_q};
            `ADDR_COMMAND: rsp_d.prdata = 32'h0000_0000;
            `ADDR_STATUS: rsp_d.prdata = {29'h0000_0000, inhibit_q, timer_pre};
            default: rsp_d.pslverr = 1'b1;
         endcase
      end
   end

   // all state registers
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         phase_q <= 2'h0;
         count_q <= 8'h00;
         option_q <= `OPTION_RESET;
         cmp1_q <= `CMP_RESET;
         cmp2_q <= `CMP_RESET;
         pre_q <= '0;
         inhibit_q <= 2'h0;
         wclr_q <= 1'b0;
         wtick_q <= 1'b0;
         pdir_q <= 1'b0;
         rsp_q <= '0;
      end
      else
      begin
         phase_q <= phase_d;
         count_q <= count_d;
         option_q <= option_d;
         cmp1_q <= cmp1_d;
         cmp2_q <= cmp2_d;
         pre_q <= pre_d;
         inhibit_q <= inhibit_d;
         wclr_q <= wclr_d;
         wtick_q <= wtick_d;
         pdir_q <= pdir_d;
         rsp_q <= rsp_d;
      end
   end

   // the answer goes out registered: pready rises one cycle into access
   assign apb_rsp.pready = rsp_q.pready & apb_req.psel & apb_req.penable;
   assign apb_rsp.pslverr = rsp_q.pslverr;
   assign apb_rsp.prdata = rsp_q.prdata;
   assign pin_direction_override = pdir_q;
   assign watchdog_clear = wclr_q;
   assign watchdog_timeout_tick = wtick_q;
   assign timer_count = count_q;
endmodule : timer0_prescaler_sync
`default_nettype wire

// ===== verif/tmr_assertions.sv
// port checker for the timer block
`timescale 1ns/100ps
`default_nettype none
module tmr_assertions
   import tmr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire tmr_pkg::apb_req_t apb_req,
   input wire tmr_pkg::apb_rsp_t apb_rsp,
   input wire logic watchdog_tick,
   input wire logic watchdog_clear,
   input wire logic watchdog_timeout_tick,
   input wire logic [7:0] timer_count
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   // access phase, count write (offset 0) and watchdog clear command (offset 0x10)
   wire logic acc = apb_req.psel && apb_req.penable;
   wire logic wr_cnt = acc && apb_req.pwrite && apb_req.paddr == 12'h000;
   wire logic wr_cmd = acc && apb_req.pwrite && apb_req.paddr == 12'h010 && apb_req.pwdata[0];
   ready_wait_a: assert property ($rose(apb_req.penable) |-> !apb_rsp.pready)
      else $error("early pready");
   ready_late_a: assert property (acc && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("late pready");
   // a count move that no write explains must be plus one, wrapping at all ones
   count_step_a: assert property ($changed(timer_count) && !$past(wr_cnt)
      |-> timer_count == 8'($past(timer_count) + 8'h01)) else $error("bad count step");
   write_hold_a: assert property (wr_cnt && apb_rsp.pready |=>
      timer_count == $past(apb_req.pwdata[7:0]) ##1 $stable(timer_count) [*3])
      else $error("count write not held");
   clear_cause_a: assert property (watchdog_clear |->
      $past(wr_cmd) || $past(wr_cmd, 2)) else $error("stray clear");
   tick_cause_a: assert property (watchdog_timeout_tick |->
      $past(watchdog_tick) || $past(watchdog_tick, 2)) else $error("stray tick");
   tick_pulse_a: assert property (watchdog_timeout_tick |=> !watchdog_timeout_tick)
      else $error("long tick");
   // prescaler has no address: anything past the status word is refused
   bad_addr_a: assert property (acc && apb_rsp.pready |->
      apb_rsp.pslverr == (apb_req.paddr > 12'h014)) else $error("bad slave error");
   cover property (wr_cnt && apb_rsp.pready);
   cover property (watchdog_clear);
   cover property (watchdog_timeout_tick);
endmodule : tmr_assertions
bind timer0_prescaler_sync tmr_assertions chk_u (.clk_sys(clk_sys), .arst_n(arst_n),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .watchdog_tick(watchdog_tick),
   .watchdog_clear(watchdog_clear), .watchdog_timeout_tick(watchdog_timeout_tick),
   .timer_count(timer_count));
`default_nettype wire

// ===== verif/pulse_source.sv
// external pulse source on the count pin
`timescale 1ns/100ps
`default_nettype none
module pulse_source
(
   input wire logic clk_sys,
   input wire logic start,
   input wire logic [7:0] edges,
   output logic pin = 1'b0,
   output logic busy = 1'b0
);
   logic [7:0] left_q = 8'h00; // edges still to make
   logic [1:0] hold_q = 2'h0; // clocks left at this level
   always @(posedge clk_sys)
   begin
      if (start)
      begin
         left_q <= edges;
         busy <= 1'b1;
      end
      else if (hold_q != 2'h0)
         hold_q <= hold_q - 2'h1;
      else if (left_q != 8'h00)
      begin
         pin <= ~pin;
         left_q <= left_q - 8'h01;
         hold_q <= 2'h1;
      end
      else
         busy <= 1'b0; // pin keeps its level: a driven input, not a bus
   end
endmodule : pulse_source
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the timer block
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import tmr_pkg::*;
   logic clk_sys, arst_n, start, wtick, rerr;
   logic [7:0] edges;
   logic [31:0] rdata;
   apb_req_t req;
   apb_rsp_t rsp;
   wire logic pin, busy, ovr, wclr, wtout;
   wire logic [7:0] cnt;
   int error_cnt = 0, checks_done = 0, cyc = 0, nclr = 0, ntick = 0, n0;
   timer0_prescaler_sync #(.PRESCALE_WIDTH(8)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
      .apb_req(req), .apb_rsp(rsp), .ext_count_pin(pin), .comparator_out(1'b0),
      .watchdog_tick(wtick), .pin_direction_override(ovr), .watchdog_clear(wclr),
      .watchdog_timeout_tick(wtout), .timer_count(cnt));
   pulse_source src_u (.clk_sys(clk_sys), .start(start), .edges(edges), .pin(pin), .busy(busy));
   initial
   begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   // watchdog tallies and hang guard
   always @(posedge clk_sys)
   begin
      nclr <= nclr + wclr;
      ntick <= ntick + wtout;
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %h, expected %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, request held until pready is seen
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      req <= '{1'b1, 1'b0, w, ad, {24'h00_0000, d}};
      @(posedge clk_sys);
      req.penable <= 1'b1;
      // look mid-cycle where the answer is settled; it stands until the next edge
      do
         @(negedge clk_sys);
      while (rsp.pready !== 1'b1 && ++n < 20);
      rdata = rsp.prdata;
      rerr = rsp.pslverr;
      @(posedge clk_sys);
      req <= '0;
   endtask : xfer
   // two reads w+4 clocks apart must differ by dlt
   task automatic span(input int w, input logic [7:0] dlt);
      logic [7:0] v;
      repeat (20) @(posedge clk_sys);
      xfer(1'b0, 12'h000, 8'h00);
      v = rdata[7:0];
      repeat (w) @(posedge clk_sys);
      xfer(1'b0, 12'h000, 8'h00);
      chk(rdata, 8'(v + dlt));
   endtask : span
   task automatic tick(input int k, input int exp);
      int s;
      s = ntick;
      repeat (k)
      begin
         wtick <= 1'b1;
         @(posedge clk_sys);
         wtick <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      chk(ntick - s, exp);
   endtask : tick
   // external mode: clear count, send k pin edges, count settles
   task automatic ext(input logic [7:0] opt, input logic [7:0] k, input logic [7:0] exp);
      xfer(1'b1, 12'h004, opt);
      xfer(1'b1, 12'h000, 8'h00);
      repeat (12) @(posedge clk_sys);
      edges <= k;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
      repeat (3) @(posedge clk_sys);
      while (busy)
         @(posedge clk_sys);
      repeat (6) @(posedge clk_sys);
      chk(cnt, exp);
   endtask : ext
   task automatic test_done();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   initial
   begin
      req = '0;
      start = 1'b0;
      edges = 8'h00;
      wtick = 1'b0;
      arst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      arst_n <= 1'b1;
      xfer(1'b0, 12'h004, 8'h00);
      chk(rdata, 8'hFF);
      xfer(1'b0, 12'h000, 8'h00);
      chk(rdata, 8'h00);
      xfer(1'b0, 12'h040, 8'h00);
      chk(rerr, 1'b1);
      chk(ovr, 1'b1);
      $display("reset test done");
      xfer(1'b1, 12'h010, 8'h01);
      xfer(1'b1, 12'h004, 8'h08);
      xfer(1'b1, 12'h000, 8'hF8);
      xfer(1'b0, 12'h000, 8'h00);
      chk(rdata, 8'hF8);
      span(36, 8'h0A);
      $display("free count test done");
      for (int r = 0; r < 8; r++)
      begin
         xfer(1'b1, 12'h004, 8'(r));
         xfer(1'b1, 12'h000, 8'h00);
         span((16 << r) - 4, 8'h02);
      end
      xfer(1'b0, 12'h014, 8'h00);
      chk(rdata[0], 1'b1);
      // second write lands mid-period: a prescaler left uncleared would tick
      xfer(1'b1, 12'h000, 8'h00);
      repeat (600) @(posedge clk_sys);
      xfer(1'b1, 12'h000, 8'h00);
      repeat (600) @(posedge clk_sys);
      xfer(1'b0, 12'h000, 8'h00);
      chk(rdata, 8'h00);
      $display("ratio test done");
      ext(8'h28, 8'h03, 8'h02);
      ext(8'h38, 8'h03, 8'h02);
      ext(8'h20, 8'h08, 8'h02);
      $display("external count test done");
      tick(4, 4);
      n0 = nclr;
      xfer(1'b1, 12'h010, 8'h01);
      xfer(1'b1, 12'h000, 8'h00);
      xfer(1'b1, 12'h010, 8'h01);
      xfer(1'b1, 12'h004, 8'h0B);
      chk(nclr > n0, 1'b1);
      tick(16, 1);
      xfer(1'b1, 12'h010, 8'h01);
      xfer(1'b1, 12'h004, 8'h00);
      tick(2, 2);
      $display("watchdog test done");
      test_done();
   end
endmodule : testbench
`default_nettype wire
